// ---- verilog/lcdw_consts.vh ----
// Constants for the segment LCD waveform driver.
`ifndef LCDW_CONSTS_VH
`define LCDW_CONSTS_VH

// Register offsets; segment RAM sits at 0x0 to 0x3.
`define LCDW_RAM_LAST 4'h3
`define LCDW_OFS_CTRL 4'h4
`define LCDW_OFS_CMD 4'h5
`define LCDW_OFS_BLINK 4'h6
`define LCDW_OFS_FPEN 4'h7
`define LCDW_OFS_STAT 4'h8

// Control register fields.
`define LCDW_CTRL_EN 0
`define LCDW_CTRL_DUTY 2:1
`define LCDW_CTRL_LPW 3
`define LCDW_CTRL_PRE 6:4
`define LCDW_CTRL_RST 8'h06

// Command register fields.
`define LCDW_CMD_BANK 0
`define LCDW_CMD_CLR 1
`define LCDW_CMD_BLANK 2
`define LCDW_CMD_RST 8'h00

// Blink control fields.
`define LCDW_BLK_ON 0
`define LCDW_BLK_MODE 1
`define LCDW_BLK_RATE 4:2
`define LCDW_BLK_RST 8'h00
`define LCDW_FPEN_RST 8'h00

// Duty codes.
`define LCDW_DUTY_HALF 2'h1
`define LCDW_DUTY_THIRD 2'h2

// Timing: half of the smallest base-clock divider of 16.
`define LCDW_HALF_DIV 11'h008
`define LCDW_BLINK_BASE 5

// Bias level codes: V0 to V3 in thirds of the LCD supply.
`define LCDW_LV0 2'h0
`define LCDW_LV1 2'h1
`define LCDW_LV2 2'h2
`define LCDW_LV3 2'h3

`endif

// ---- verilog/lcdw_driver.v ----
// Segment LCD waveform driver with segment RAM and register port.
`timescale 1ns/1ps
`include "lcdw_consts.vh"

module lcdw_driver
(
    input wire ref_clk,
    input wire rst,
    input wire lcd_clk_in,
    input wire [3:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [7:0] bus_rdata,
    output reg [15:0] fp_level_q,
    output reg [7:0] fp_oe_q,
    output reg [7:0] bp_level_q,
    output reg [3:0] bp_oe_q
);

    // One-hot backplane phase states.
    localparam [3:0] ST_BP0 = 4'h1;
    localparam [3:0] ST_BP1 = 4'h2;
    localparam [3:0] ST_BP2 = 4'h4;
    localparam [3:0] ST_BP3 = 4'h8;

    reg [7:0] ctrl_q;
    reg [7:0] cmd_q;
    reg [7:0] blink_q;
    reg [7:0] fpen_q;
    reg [7:0] mem_on [0:3];
    reg [7:0] mem_blk [0:3];
    reg lclk_prev_q;
    reg [10:0] div_cnt_q;
    reg half_q;
    reg [3:0] st_q;
    reg [3:0] st_d;
    reg frame_q;
    reg [11:0] blink_cnt_q;
    reg blink_act_q;
    reg [1:0] cur_bp;
    reg [7:0] rd_d;
    reg [7:0] bp_level_d;
    reg [3:0] bp_oe_d;

    wire enable;
    wire [1:0] duty;
    wire waveform_shape_sel;
    wire [2:0] presc;
    wire bank_sel;
    wire blank;
    wire blink_on;
    wire blink_mode;
    wire [2:0] rate;
    wire ram_hit;
    wire clr_cmd;
    wire clr_bank;
    wire lclk_rise;
    wire [10:0] half_lim;
    wire half_end;
    wire base_end;
    wire last_phase;
    wire frame_end;
    wire blink_off;
    wire pol;
    wire [31:0] on_flat;
    wire [31:0] blk_flat;
    wire [15:0] fp_level_d;

    assign enable = ctrl_q[`LCDW_CTRL_EN];
    assign duty = ctrl_q[`LCDW_CTRL_DUTY];
    assign waveform_shape_sel = ctrl_q[`LCDW_CTRL_LPW];
    assign presc = ctrl_q[`LCDW_CTRL_PRE];
    assign bank_sel = cmd_q[`LCDW_CMD_BANK];
    assign blank = cmd_q[`LCDW_CMD_BLANK];
    assign blink_on = blink_q[`LCDW_BLK_ON];
    assign blink_mode = blink_q[`LCDW_BLK_MODE];
    assign rate = blink_q[`LCDW_BLK_RATE];

    // The clear takes the bank bit written alongside it.
    // Using the new bank bit lets software select and clear a bank in one write.
    assign ram_hit = bus_addr <= `LCDW_RAM_LAST;
    assign clr_cmd = bus_wr & (bus_addr == `LCDW_OFS_CMD)
                     & bus_wdata[`LCDW_CMD_CLR];
    assign clr_bank = bus_wdata[`LCDW_CMD_BANK];

    // Control registers; of the control writes only a command clear reaches the segment RAM.
    // Reserved bits are masked on the way in, so they always read back as zero.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= `LCDW_CTRL_RST;
            cmd_q <= `LCDW_CMD_RST;
            blink_q <= `LCDW_BLK_RST;
            fpen_q <= `LCDW_FPEN_RST;
        end
        else if (bus_wr)
        begin
            case (bus_addr)
                `LCDW_OFS_CTRL: ctrl_q <= bus_wdata & 8'h7f;
                `LCDW_OFS_CMD:
                begin
                    // The clear bit is a strobe and is not held.
                    cmd_q <= bus_wdata & 8'h05;
                end
                `LCDW_OFS_BLINK: blink_q <= bus_wdata & 8'h1f;
                `LCDW_OFS_FPEN: fpen_q <= bus_wdata;
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // Segment RAM has no reset, so its contents start undefined.
    // A clear and a plain RAM write cannot meet, since each needs its own bus_wr cycle.
    // Leaving out the reset keeps the storage a plain array that maps onto RAM cells.
    integer i;
    always @(posedge ref_clk)
    begin
        if (clr_cmd)
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                if (clr_bank)
                    mem_blk[i] <= 8'h00;
                else
                    mem_on[i] <= 8'h00;
            end
        end
        else if (bus_wr & ram_hit)
        begin
            // Writes work with the module disabled too.
            if (bank_sel)
                mem_blk[bus_addr[1:0]] <= bus_wdata;
            else
                mem_on[bus_addr[1:0]] <= bus_wdata;
        end
    end

    // Read mux; unmapped offsets answer zero.
    // The status word shows phase, half, frame parity and blink state for software.
    always @*
    begin
        rd_d = 8'h00;
        if (ram_hit)
            rd_d = bank_sel ? mem_blk[bus_addr[1:0]] : mem_on[bus_addr[1:0]];
        else if (bus_addr == `LCDW_OFS_CTRL)
            rd_d = ctrl_q;
        else if (bus_addr == `LCDW_OFS_CMD)
            rd_d = cmd_q;
        else if (bus_addr == `LCDW_OFS_BLINK)
            rd_d = blink_q;
        else if (bus_addr == `LCDW_OFS_FPEN)
            rd_d = fpen_q;
        else if (bus_addr == `LCDW_OFS_STAT)
            rd_d = {2'h0, blink_act_q, blink_off, frame_q, half_q, cur_bp};
    end

    // Read data stand for one cycle after the strobe, else zero.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            bus_rdata <= 8'h00;
        else if (bus_rd)
            bus_rdata <= rd_d;
        else
            bus_rdata <= 8'h00;
    end

    // The LCD clock is slow and synchronous, so an edge is a sample pair.
    // Limitation: the LCD clock must stay well below half the bus clock, or rises are lost.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            lclk_prev_q <= 1'b0;
        else
            lclk_prev_q <= lcd_clk_in;
    end

    assign lclk_rise = lcd_clk_in & ~lclk_prev_q;

    // Each half of a base period is 8 times 2^prescale input clocks.
    assign half_lim = (`LCDW_HALF_DIV << presc) - 11'h001;
    // Comparing with >= means a smaller prescale written while running cannot strand the
    // counter above its new limit for a full 11-bit wrap.
    assign half_end = lclk_rise & (div_cnt_q >= half_lim);
    assign base_end = half_end & half_q;

    // Base-clock divider; held while the module is disabled.
    // Holding it cleared means the first half period after enable is always whole.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt_q <= 11'h000;
            half_q <= 1'b0;
        end
        else if (!enable)
        begin
            div_cnt_q <= 11'h000;
            half_q <= 1'b0;
        end
        else if (half_end)
        begin
            div_cnt_q <= 11'h000;
            half_q <= ~half_q;
        end
        else if (lclk_rise)
            div_cnt_q <= div_cnt_q + 11'h001;
    end

    // Last active phase depends on the duty; 00 acts like 1/4.
    assign last_phase = (duty == `LCDW_DUTY_HALF) ? st_q[1] :
                        (duty == `LCDW_DUTY_THIRD) ? st_q[2] : st_q[3];
    assign frame_end = base_end & last_phase;

    // Phase sequencer: one backplane per base period.
    // Duty 00 has no meaning of its own and falls back to the quarter sequence.
    always @*
    begin
        case (st_q)
            ST_BP0: st_d = ST_BP1;
            ST_BP1: st_d = (duty == `LCDW_DUTY_HALF) ? ST_BP0 : ST_BP2;
            ST_BP2: st_d = (duty == `LCDW_DUTY_THIRD) ? ST_BP0 : ST_BP3;
            ST_BP3: st_d = ST_BP0;
            default: st_d = ST_BP0;
        endcase
    end

    // Duty changes may leave the state past the last phase; it then runs on through ST_BP3 back to ST_BP0.
    // Disabling parks the sequence at the first backplane, so each enable starts a clean frame.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            st_q <= ST_BP0;
        else if (!enable)
            st_q <= ST_BP0;
        else if (frame_end)
            st_q <= ST_BP0;
        else if (base_end)
            st_q <= st_d;
    end

    // Index of the backplane now active.
    // It selects one bit per frontplane out of the flattened segment RAM.
    always @*
    begin
        case (st_q)
            ST_BP1: cur_bp = 2'h1;
            ST_BP2: cur_bp = 2'h2;
            ST_BP3: cur_bp = 2'h3;
            default: cur_bp = 2'h0;
        endcase
    end

    // Frame parity drives the low-power polarity swap.
    // Swapping once per frame keeps every cell free of DC over each pair of frames.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            frame_q <= 1'b0;
        else if (!enable)
            frame_q <= 1'b0;
        else if (frame_end)
            frame_q <= ~frame_q;
    end

    // Blink counter in base periods; 4096 wraps evenly for every rate.
    // Twelve bits are enough for the longest period, so no extra compare logic is needed.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            blink_cnt_q <= 12'h000;
        else if (!enable)
            blink_cnt_q <= 12'h000;
        else if (base_end)
            blink_cnt_q <= blink_cnt_q + 12'h001;
    end

    // Top bit of a 2^(5+rate) period marks its off half.
    assign blink_off = blink_cnt_q[`LCDW_BLINK_BASE - 1 + rate];

    // Blink on/off is sampled at a frame boundary and followed freely while disabled, so a frame
    // never straddles a change of the blink enable.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            blink_act_q <= 1'b0;
        else if (!enable)
            blink_act_q <= blink_on;
        else if (frame_end)
            blink_act_q <= blink_on;
    end

    // Normal shape flips within each phase; low-power flips per frame.
    // The low-power shape switches less often and so charges the glass less.
    assign pol = waveform_shape_sel ? frame_q : half_q;

    assign on_flat = {mem_on[3], mem_on[2], mem_on[1], mem_on[0]};
    assign blk_flat = {mem_blk[3], mem_blk[2], mem_blk[1], mem_blk[0]};

    // Frontplane n owns bits 4n to 4n+3, one per backplane.
    // Blank and blink only change what is shown, never the stored bits.
    genvar n;
    generate
        for (n = 0; n < 8; n = n + 1)
        begin : g_fp
            wire on_b;
            wire blk_b;
            wire lit;
            assign on_b = on_flat[n * 4 + cur_bp];
            assign blk_b = blk_flat[n * 4 + cur_bp];
            // Blank overrides everything but timing.
            assign lit = on_b & ~blank
                         & ~(blink_act_q & blink_off & (blink_mode | blk_b));
            // On sits opposite the active backplane, off at 1/3 from it.
            assign fp_level_d[2 * n + 1:2 * n] = lit ?
                (pol ? `LCDW_LV3 : `LCDW_LV0) :
                (pol ? `LCDW_LV1 : `LCDW_LV2);
        end
    endgenerate

    // Backplane levels: active at the rail, idle at the inner levels.
    // Unused backplanes still get levels and only lose their enable, which keeps the loop uniform.
    integer b;
    always @*
    begin
        bp_level_d = 8'h00;
        bp_oe_d = 4'h0;
        for (b = 0; b < 4; b = b + 1)
        begin
            if (st_q[b])
            begin
                bp_level_d[2 * b +: 2] = pol ? `LCDW_LV0 : `LCDW_LV3;
            end
            else
            begin
                bp_level_d[2 * b +: 2] = pol ? `LCDW_LV2 : `LCDW_LV1;
            end
        end
        // Unused backplanes are left undriven.
        if (duty == `LCDW_DUTY_HALF)
            bp_oe_d = 4'h3;
        else if (duty == `LCDW_DUTY_THIRD)
            bp_oe_d = 4'h7;
        else
            bp_oe_d = 4'hf;
    end

    // Output flops; everything is quiet while the module is disabled.
    // Every pin comes from a flop, so the glass never sees a decode glitch.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            fp_level_q <= 16'h0000;
            fp_oe_q <= 8'h00;
            bp_level_q <= 8'h00;
            bp_oe_q <= 4'h0;
        end
        else if (!enable)
        begin
            fp_level_q <= 16'h0000;
            fp_oe_q <= 8'h00;
            bp_level_q <= 8'h00;
            bp_oe_q <= 4'h0;
        end
        else
        begin
            fp_level_q <= fp_level_d;
            fp_oe_q <= fpen_q;
            bp_level_q <= bp_level_d;
            bp_oe_q <= bp_oe_d;
        end
    end

endmodule

// ---- testbench/lcdw_props.sv ----
// Port assertions for the segment LCD waveform driver.
`timescale 1ns/1ps
module lcdw_props
(
    input wire ref_clk,
    input wire rst,
    input wire [3:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_rdata,
    input wire [15:0] fp_level_q,
    input wire [7:0] fp_oe_q,
    input wire [7:0] bp_level_q,
    input wire [3:0] bp_oe_q
);
    reg [6:0] ctl_q;
    reg blank_q;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // Shadow of control and blank bits, so the waveform can be tied to them.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctl_q <= 7'h06;
            blank_q <= 1'b0;
        end
        else if (bus_wr && bus_addr == 4'h4)
            ctl_q <= bus_wdata[6:0];
        else if (bus_wr && bus_addr == 4'h5)
            blank_q <= bus_wdata[2];
    end
    function [2:0] ext(input [1:0] v);
        ext = {2'h0, v == 2'h0 || v == 2'h3};
    endfunction
    // Only the active backplane sits at an extreme level.
    wire [2:0] n_act = ext(bp_level_q[1:0]) + ext(bp_level_q[3:2]) + ext(bp_level_q[5:4]) + ext(bp_level_q[7:6]);
    wire on = ctl_q[0];
    wire [1:0] dty = ctl_q[2:1];
    a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 8'h00)
        else $error("read data not idle");
    a_ctrl_read: assert property (bus_rd && bus_addr == 4'h4 |=> bus_rdata == {1'b0, ctl_q})
        else $error("control readback wrong");
    a_off_disabled: assert property (!on [*3] |-> fp_oe_q == 8'h00 && bp_oe_q == 4'h0)
        else $error("outputs driven while disabled");
    a_half_idle: assert property ((on && dty == 2'h1) [*4] |-> bp_oe_q == 4'h3)
        else $error("half duty backplanes wrong");
    a_third_idle: assert property ((on && dty == 2'h2) [*4] |-> bp_oe_q == 4'h7)
        else $error("third duty backplanes wrong");
    a_quarter_all: assert property ((on && dty == 2'h3) [*4] |-> bp_oe_q == 4'hf && n_act == 3'h1)
        else $error("quarter duty backplanes wrong");
    a_blank_unlit: assert property ((on && blank_q && fp_oe_q[0]) [*4] |->
        fp_level_q[1:0] == 2'h1 || fp_level_q[1:0] == 2'h2)
        else $error("blanked frontplane lit");
    a_bp_hold: assert property ($changed(bp_level_q) && on && $past(on) |=>
        ($stable(bp_level_q) || !on) [*8])
        else $error("backplane level changed too soon");
    c_blank: cover property (on && blank_q);
    c_third: cover property (on && dty == 2'h2);
    c_lowpow: cover property (on && ctl_q[3]);
endmodule
bind lcdw_driver lcdw_props u_props (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .fp_level_q(fp_level_q), .fp_oe_q(fp_oe_q),
    .bp_level_q(bp_level_q), .bp_oe_q(bp_oe_q));

// ---- testbench/lcdw_glass.sv ----
// Glass model: which cells on frontplane 0 see the full drive swing.
`timescale 1ns/1ps
module lcdw_glass
(
    input wire [1:0] fp0,
    input wire fp0_oe,
    input wire [7:0] bp_level,
    input wire [3:0] bp_oe,
    output wire [3:0] seg_lit
);
    genvar b;
    // A cell turns on only between opposite extreme levels.
    generate
        for (b = 0; b < 4; b = b + 1)
        begin : g_cell
            assign seg_lit[b] = fp0_oe && bp_oe[b] &&
                ({fp0, bp_level[2*b+:2]} == 4'hc || {fp0, bp_level[2*b+:2]} == 4'h3);
        end
    endgenerate
endmodule

// ---- testbench/lcdw_driver_test.sv ----
// Self-checking testbench for the segment LCD waveform driver.
`timescale 1ns/1ps
module lcdw_driver_test;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg lcd_clk_in = 1'b0;
    reg [1:0] lcd_div = 2'h0;
    reg [3:0] bus_addr = 4'h0;
    reg [7:0] bus_wdata = 8'h00;
    reg bus_wr = 1'b0;
    reg bus_rd = 1'b0;
    wire [7:0] bus_rdata;
    wire [15:0] fp_level_q;
    wire [7:0] fp_oe_q;
    wire [7:0] bp_level_q;
    wire [3:0] bp_oe_q;
    wire [3:0] seg_lit;
    int err_total = 0;
    int checked = 0;
    reg [7:0] v;
    int c, l, f, k, m, lt, a0;
    lcdw_driver uut (.ref_clk(ref_clk), .rst(rst), .lcd_clk_in(lcd_clk_in), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .fp_level_q(fp_level_q),
        .fp_oe_q(fp_oe_q), .bp_level_q(bp_level_q), .bp_oe_q(bp_oe_q));
    lcdw_glass glass (.fp0(fp_level_q[1:0]), .fp0_oe(fp_oe_q[0]), .bp_level(bp_level_q), .bp_oe(bp_oe_q),
        .seg_lit(seg_lit));
    // The LCD clock is sped up to four bus cycles so a base period is 64 cycles.
    always #4 ref_clk = ~ref_clk;
    // The LCD clock is built at the rising bus clock edge, so it stays synchronous.
    always @(posedge ref_clk)
    begin
        lcd_div <= lcd_div + 2'h1;
        lcd_clk_in <= lcd_div[1];
    end
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            bus_addr <= a;
            bus_wdata <= d;
            bus_wr <= 1'b1;
            @(posedge ref_clk);
            bus_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge ref_clk);
            bus_addr <= a;
            bus_rd <= 1'b1;
            @(posedge ref_clk);
            bus_rd <= 1'b0;
            #1;
            v = bus_rdata;
        end
    endtask
    task chk_v(input string n, input [7:0] e, input [7:0] g);
        begin
            checked++;
            if (g !== e)
            begin
                err_total++;
                $display("[ERR] %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task chk_n(input string n, input int e, input int g);
        begin
            checked++;
            if (g != e)
            begin
                err_total++;
                $display("[ERR] %s expected %0d seen %0d", n, e, g);
            end
        end
    endtask
    task rd4(input [7:0] b, input [7:0] s);
        begin
            for (k = 0; k < 4; k++)
            begin
                rd(4'(k));
                chk_v("ram byte", b + s * 8'(k), v);
            end
        end
    endtask
    function automatic int act();
        int b;
        act = 4;
        for (b = 3; b >= 0; b--)
            if (bp_oe_q[b] && (bp_level_q[2*b+:2] == 2'h0 || bp_level_q[2*b+:2] == 2'h3))
                act = b;
    endfunction
    // Waits for the active backplane to move on; counts cycles, lit cycles and level steps.
    task next_phase;
        reg [7:0] p;
        begin
            a0 = act();
            p = bp_level_q;
            c = 0;
            l = 0;
            f = 0;
            while (act() == a0 && c < 9000)
            begin
                @(posedge ref_clk);
                #1;
                c++;
                l += seg_lit[0];
                f += (bp_level_q !== p);
                p = bp_level_q;
            end
        end
    endtask
    task run(input int np, input [2:0] pr, input s);
        begin
            lt = 0;
            repeat (np)
            begin
                next_phase();
                lt += l;
                chk_n("phase cycles", 64 << pr, c);
                chk_n("level steps", s ? 1 : 2, f);
            end
        end
    endtask
    task t_regs;
        begin
            for (m = 4; m < 9; m++)
            begin
                rd(m == 8 ? 4'hc : 4'(m));
                chk_v("reset value", m == 4 ? 8'h06 : 8'h00, v);
            end
            $display("register test done");
        end
    endtask
    task t_ram;
        begin
            for (m = 0; m < 8; m++)
            begin
                if (m % 4 == 0)
                    wr(4'h5, m == 0 ? 8'h00 : 8'h01);
                wr(4'(m % 4), m < 4 ? 8'ha0 + 8'(m) : 8'h50 + 8'(m % 4));
            end
            wr(4'h4, 8'h07);
            wr(4'h4, 8'h06);
            wr(4'h5, 8'h05);
            rd4(8'h50, 8'h01);
            wr(4'h5, 8'h00);
            rd4(8'ha0, 8'h01);
            wr(4'h5, 8'h03);
            rd4(8'h00, 8'h00);
            wr(4'h5, 8'h00);
            rd4(8'ha0, 8'h01);
            wr(4'h5, 8'h02);
            rd4(8'h00, 8'h00);
            wr(4'h0, 8'h01);
            $display("ram test done");
        end
    endtask
    task t_wave(input [1:0] d, input s, input [2:0] pr);
        int n;
        begin
            n = d == 2'h1 ? 2 : d == 2'h2 ? 3 : 4;
            wr(4'h7, 8'hff);
            wr(4'h4, {1'b0, pr, s, d, 1'b1});
            next_phase();
            next_phase();
            m = act();
            run(n, pr, s);
            chk_n("frame wrap", m, act());
            chk_n("lit cycles", 64 << pr, lt);
            chk_v("bp enables", 8'((1 << n) - 1), {4'h0, bp_oe_q});
            wr(4'h4, 8'h06);
            $display("waveform test done");
        end
    endtask
    // Blink at rate r repeats every 2^(5+r) base periods, half dark; en sets the byte 0 blink enables.
    task t_blink(input [7:0] b, input [7:0] en, input int e);
        begin
            wr(4'h5, 8'h01);
            wr(4'h0, en);
            wr(4'h4, 8'h07);
            wr(4'h6, b);
            wr(4'h5, e == 0 ? 8'h04 : 8'h00);
            // Skip the partial first phase so that every counted phase is whole.
            next_phase();
            next_phase();
            run(8, 3'h0, 1'b0);
            run(32, 3'h0, 1'b0);
            chk_n("lit over blink period", e, lt);
            wr(4'h4, 8'h06);
            $display("blink test done");
        end
    endtask
    // Watchdog: the whole run needs about 16000 bus cycles.
    initial
    begin
        #400000;
        err_total++;
        wrap_up();
    end
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_ram();
        for (k = 0; k < 8; k++)
            t_wave(2'(k / 2 + 1), 1'(k % 2), 3'(k / 7));
        t_blink(8'h03, 8'h00, 256);
        t_blink(8'h07, 8'h00, 320);
        t_blink(8'h01, 8'h00, 512);
        t_blink(8'h01, 8'h01, 256);
        t_blink(8'h00, 8'h00, 0);
        wrap_up();
    end
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
endmodule
